// ===== hdl/reset_wake_strap_control.sv
// Purpose: Reset, wake and strap latching for an Ethernet controller
// Assumes: Host strobes are active low and synchronous to clk_i
// Notes: Wake event sources lie outside this block
`default_nettype none

module reset_wake_strap_control #(
  parameter int unsigned POR_CYCLES = rst_wake_pkg::POR_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic hard_reset_in_n_i,
  // Straps
  input wire logic speed_strap_i,
  input wire logic crossover_auto_enable_pin_i,
  // Host strobes
  input wire logic chip_select_in_n_i,
  input wire logic write_strobe_in_n_i,
  input wire logic read_strobe_n_i,
  // Power control
  input wire logic sleep_request_i,
  input wire logic wake_event_i,
  input wire rst_wake_pkg::wake_cfg_type wake_cfg_i,
  // Status
  output logic rst_n_o,
  output logic write_enable_o,
  output logic sleeping_o,
  output rst_wake_pkg::link_cfg_type link_cfg_o,
  // Wake pin
  output logic wake_indicator_out_o,
  output logic wake_indicator_out_oe_o
);
  rst_wake_pkg::pwr_state_type state, next_state;
  logic rst_n;
  logic strap_taken;
  logic wake_pending;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reset_sync #(
    .POR_CYCLES(POR_CYCLES)
  ) u_reset_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .hard_reset_in_n_i(hard_reset_in_n_i),
    .rst_n_o(rst_n)
  );

  // ----------------------------------------
  // Host cycle decode
  // ----------------------------------------
  wire host_write = !chip_select_in_n_i && !write_strobe_in_n_i;
  wire host_read = !chip_select_in_n_i && !read_strobe_n_i;

  always_comb begin
    next_state = state;
    unique case (state)
      rst_wake_pkg::PWR_RESET: next_state = rst_wake_pkg::PWR_WAIT_READ;
      rst_wake_pkg::PWR_WAIT_READ: begin
        if (host_read) begin
          next_state = rst_wake_pkg::PWR_ACTIVE;
        end
      end
      rst_wake_pkg::PWR_ACTIVE: begin
        if (sleep_request_i) begin
          next_state = rst_wake_pkg::PWR_SLEEP;
        end
      end
      rst_wake_pkg::PWR_SLEEP: begin
        if (host_write) begin
          next_state = rst_wake_pkg::PWR_WAIT_READ;
        end
      end
    endcase
  end

  // ----------------------------------------
  // State and straps
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= rst_wake_pkg::PWR_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken <= 1'b0;
      link_cfg_o.speed_100 <= rst_wake_pkg::SPEED_STRAP_DEFAULT;
      link_cfg_o.full_duplex <= 1'b0;
      link_cfg_o.autoneg_en <= rst_wake_pkg::SPEED_STRAP_DEFAULT;
      link_cfg_o.crossover_auto <= rst_wake_pkg::CROSSOVER_DEFAULT;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      link_cfg_o.speed_100 <= speed_strap_i;
      link_cfg_o.full_duplex <= 1'b0;
      link_cfg_o.autoneg_en <= speed_strap_i;
      link_cfg_o.crossover_auto <= crossover_auto_enable_pin_i;
    end
  end

  // ----------------------------------------
  // Wake indicator
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_pending <= 1'b0;
    end else if (wake_cfg_i.enable && wake_event_i && state == rst_wake_pkg::PWR_SLEEP) begin
      wake_pending <= 1'b1;
    end else if (state != rst_wake_pkg::PWR_SLEEP) begin
      wake_pending <= 1'b0;
    end
  end

  wake_pin_drive u_wake_pin_drive (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .asserted_i(wake_pending),
    .cfg_i(wake_cfg_i),
    .pin_o(wake_indicator_out_o),
    .pin_oe_o(wake_indicator_out_oe_o)
  );

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rst_n_o <= 1'b0;
      write_enable_o <= 1'b0;
      sleeping_o <= 1'b0;
    end else begin
      rst_n_o <= 1'b1;
      write_enable_o <= (next_state == rst_wake_pkg::PWR_ACTIVE);
      sleeping_o <= (next_state == rst_wake_pkg::PWR_SLEEP);
    end
  end
endmodule
`default_nettype wire

// ===== hdl/rst_wake_pkg.sv
// Purpose: Shared constants and types for reset, wake and strap control
// Assumes: Single 40 MHz clock
// Notes: Pins are sampled as synchronous inputs
`default_nettype none
package rst_wake_pkg;
  // ----------------------------------------
  // Reset and strap constants
  // ----------------------------------------
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned POR_CYCLES = 16;
  localparam logic [4:0] POR_COUNT_RESET = 5'h00;
  localparam logic SPEED_STRAP_DEFAULT = 1'b1;
  localparam logic CROSSOVER_DEFAULT = 1'b0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PWR_RESET = 2'b00,
    PWR_WAIT_READ = 2'b01,
    PWR_ACTIVE = 2'b10,
    PWR_SLEEP = 2'b11
  } pwr_state_type;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic autoneg_en;
    logic crossover_auto;
  } link_cfg_type;

  typedef struct packed {
    logic enable;
    logic active_high;
    logic open_drain;
  } wake_cfg_type;
endpackage
`default_nettype wire

// ===== hdl/reset_sync.sv
// Purpose: Power-on fallback and reset release synchroniser
// Assumes: hard_reset_in_n_i sampled on clk_i
// Notes: Release happens on one clock edge for all state
`default_nettype none
module reset_sync #(
  parameter int unsigned POR_CYCLES = rst_wake_pkg::POR_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Reset pin
  input wire logic hard_reset_in_n_i,
  // Synchronised reset
  output logic rst_n_o
);
  logic [rst_wake_pkg::SYNC_STAGES-1:0] sync;
  logic [4:0] por_count;
  wire por_done = (por_count == 5'(POR_CYCLES));
  wire pin_released = sync[rst_wake_pkg::SYNC_STAGES-1];

  // ----------------------------------------
  // Synchroniser and power-on counter
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync <= '0;
      por_count <= rst_wake_pkg::POR_COUNT_RESET;
    end else begin
      sync <= {sync[rst_wake_pkg::SYNC_STAGES-2:0], hard_reset_in_n_i};
      if (!por_done) begin
        por_count <= por_count + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_n_o <= 1'b0;
    end else begin
      rst_n_o <= por_done & pin_released;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/wake_pin_drive.sv
// Purpose: Wake indicator pin driver with polarity and driver style
// Assumes: Configuration held stable by software
// Notes: Open-drain drives only the low level, whichever polarity is set
`default_nettype none
module wake_pin_drive (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic asserted_i,
  input wire rst_wake_pkg::wake_cfg_type cfg_i,
  // Pin
  output logic pin_o,
  output logic pin_oe_o
);
  wire level = asserted_i ~^ cfg_i.active_high;
  wire drive = cfg_i.open_drain ? (level == 1'b0) : 1'b1;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      pin_o <= cfg_i.open_drain ? 1'b0 : level;
      pin_oe_o <= drive;
    end
  end
endmodule
`default_nettype wire

// ===== bench/host_cpu_model.sv
// Purpose: Host CPU strobe model
// Assumes: Strobes change 1 ns after a rising edge
// Notes: One-cycle accesses, no address bus
`default_nettype none
module host_cpu_model (
  // Clock
  input wire logic clk_i,
  // Strobes
  output logic cs_n_o,
  output logic wr_n_o,
  output logic rd_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {cs_n_o, wr_n_o, rd_n_o} = 3'h7;
  // Write 1 is the wake write to the endian check word, read first after reset or wake
  task automatic access(input bit wr);
    @(posedge clk_i);
    #1 {cs_n_o, wr_n_o, rd_n_o} = {1'b0, !wr, wr};
    @(posedge clk_i);
    #1 {cs_n_o, wr_n_o, rd_n_o} = 3'h7;
  endtask
endmodule
`default_nettype wire

// ===== bench/reset_wake_strap_control_sva.sv
// Purpose: Port checks for reset, wake and strap control
// Assumes: One clock domain
// Notes: Bound to the top module
`default_nettype none
module reset_wake_strap_control_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Inputs
  input wire logic chip_select_in_n_i,
  input wire logic write_strobe_in_n_i,
  input wire logic read_strobe_n_i,
  input wire logic wake_event_i,
  input wire rst_wake_pkg::wake_cfg_type wake_cfg_i,
  // Outputs
  input wire logic rst_n_o,
  input wire logic write_enable_o,
  input wire logic sleeping_o,
  input wire rst_wake_pkg::link_cfg_type link_cfg_o,
  input wire logic wake_indicator_out_o,
  input wire logic wake_indicator_out_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  wire rd_cyc = !chip_select_in_n_i && !read_strobe_n_i;
  wire wr_cyc = !chip_select_in_n_i && !write_strobe_in_n_i;
  wire od = wake_cfg_i.open_drain;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  rst_clear_a: assert property (!rst_n_o |-> !write_enable_o && !sleeping_o) else $error("reset state");
  read_first_a: assert property ($rose(write_enable_o) |-> $past(rd_cyc) || $past(rd_cyc, 2))
    else $error("write enable without read");
  wake_write_a: assert property (sleeping_o && wr_cyc |-> ##[1:2] !sleeping_o) else $error("no wake");
  stay_asleep_a: assert property ($fell(sleeping_o) && rst_n_o |-> $past(wr_cyc) || $past(wr_cyc, 2))
    else $error("woke without write");
  link_hold_a: assert property (rst_n_o && $past(rst_n_o) |-> $stable(link_cfg_o))
    else $error("link settings moved");
  pin_idle_a: assert property ((rst_n_o && !sleeping_o && !od && $stable(wake_cfg_i))[*3] |->
    wake_indicator_out_oe_o && wake_indicator_out_o == !wake_cfg_i.active_high) else $error("pin idle");
  wake_pin_a: assert property (sleeping_o && wake_event_i && wake_cfg_i.enable && !od |->
    ##[1:3] wake_indicator_out_o == wake_cfg_i.active_high) else $error("pin not asserted");
  od_low_a: assert property (wake_indicator_out_oe_o && od |-> !wake_indicator_out_o) else $error("od high");
  cover property ($rose(write_enable_o));
  cover property ($fell(sleeping_o));
  cover property (sleeping_o && wake_indicator_out_oe_o);
endmodule
bind reset_wake_strap_control reset_wake_strap_control_sva i_reset_wake_strap_control_sva (.*);
`default_nettype wire

// ===== bench/tb_reset_wake_strap_control.sv
// Purpose: Self-checking bench for reset, wake and strap control
// Assumes: 40 MHz clock, POR_CYCLES of 4
// Notes: Strap rows and sleep cases in tables
`default_nettype none
module tb_reset_wake_strap_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, arst_n_i = 0, hrst_n = 1, spd = 1, xov = 0, slp = 0, evt = 0;
  logic cs_n, wr_n, rd_n, rst_n, we, sl, pin, oe;
  rst_wake_pkg::wake_cfg_type cfg = '0;
  rst_wake_pkg::link_cfg_type lcfg;
  int num_errors = 0, n_compared = 0;
  // Straps, expected link settings
  logic [5:0] rows [4] = '{6'h00, 6'h11, 6'h2A, 6'h3B};
  // Wake config, asserted oe and pin, idle oe
  logic [5:0] slps [3] = '{6'h37, 6'h2C, 6'h15};
  always #12.5 clk_i = !clk_i;
  host_cpu_model i_host_cpu_model (.clk_i, .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n));
  reset_wake_strap_control #(.POR_CYCLES(4)) i_reset_wake_strap_control (.clk_i, .arst_n_i,
    .hard_reset_in_n_i(hrst_n), .speed_strap_i(spd), .crossover_auto_enable_pin_i(xov),
    .chip_select_in_n_i(cs_n), .write_strobe_in_n_i(wr_n), .read_strobe_n_i(rd_n),
    .sleep_request_i(slp), .wake_event_i(evt), .wake_cfg_i(cfg), .rst_n_o(rst_n), .write_enable_o(we),
    .sleeping_o(sl), .link_cfg_o(lcfg), .wake_indicator_out_o(pin), .wake_indicator_out_oe_o(oe));
  task automatic chk(input string nm, input logic [3:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic up;
    for (int i = 0; i < 40 && rst_n !== 1'b1; i++) cyc(1);
  endtask
  task automatic report_and_stop;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #50us;
    num_errors++;
    report_and_stop;
  end
  initial begin
    cyc(6);
    arst_n_i = 1;
    up;
    chk("link", 4'hA, lcfg);
    foreach (rows[k]) begin
      {spd, xov} = rows[k][5:4];
      hrst_n = 0;
      cyc(6);
      chk("reset", 4'h0, {sl, we, oe, rst_n});
      hrst_n = 1;
      up;
      {spd, xov} = ~rows[k][5:4];
      cyc(2);
      chk("link", rows[k][3:0], lcfg);
      i_host_cpu_model.access(1);
      cyc(1);
      chk("we", 4'h0, {3'h0, we});
      i_host_cpu_model.access(0);
      cyc(1);
      chk("we", 4'h1, {3'h0, we});
    end
    foreach (slps[k]) begin
      cfg = slps[k][5:3];
      slp = 1;
      cyc(1);
      slp = 0;
      cyc(2);
      chk("oe", {3'h0, slps[k][0]}, {3'h0, oe});
      evt = 1;
      cyc(1);
      evt = 0;
      cyc(4);
      chk("pin", {2'h0, slps[k][2:1]}, {2'h0, oe, pin});
      chk("sleep", 4'h2, {2'h0, sl, we});
      i_host_cpu_model.access(1);
      cyc(2);
      chk("sleep", 4'h0, {2'h0, sl, we});
      i_host_cpu_model.access(0);
      cyc(1);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
